// File: rtl/pvr_pkg.sv
// Purpose: shared constants for the phy vendor register pair and its manager
// Assumes: 16-bit registers, 5-bit register and station addresses
// Notes: offsets are management register numbers, apb offsets are byte addresses
package pvr_pkg;
    localparam logic [4:0] reg_result_addr = 5'h11;
    localparam logic [4:0] reg_line_cfg = 5'h12;
    localparam logic [4:0] reg_basic_control = 5'h00;
    localparam logic [4:0] station_addr_reset = 5'h01;
    localparam logic [3:0] result_reset = 4'hf;
    localparam logic [3:0] monitor_reset = 4'h0;
    localparam logic [15:0] line_cfg_reset = 16'h7800;
    localparam logic [15:0] line_cfg_wmask = 16'h7800;
    localparam int addr_lsb = 4;
    localparam int result_lsb = 12;
    localparam int basic_isolate_bit = 10;
    localparam int lp_bit = 14;
    localparam int hb_bit = 13;
    localparam int sq_bit = 12;
    localparam int jab_bit = 11;
    // 2 start, 2 op, 5 phy, 5 reg, 2 turnaround, 16 data
    localparam logic [5:0] frame_bits = 6'h20;
    localparam logic [11:0] apb_ctrl = 12'h000;
    localparam logic [11:0] apb_wdata = 12'h004;
    localparam logic [11:0] apb_status = 12'h008;
    localparam logic [11:0] apb_rdata = 12'h00c;
    typedef enum logic [3:0] {
        mon_idle = 4'b0000,
        mon_ack_match = 4'b0010,
        mon_ack_fail = 4'b0011,
        mon_cons_match = 4'b0100,
        mon_cons_fail = 4'b0101,
        mon_pd_ready = 4'b0110,
        mon_pd_fail = 4'b0111,
        mon_done = 4'b1000
    } pvr_monitor_type;
endpackage

// File: rtl/pvr_mgmt_if.sv
// Purpose: serial management link between manager and phy register pair
// Assumes: single clock, manager drives bit_strobe as the bit strobe
// Notes: data line is shared; the wire level is resolved here
`timescale 1ns/100ps
interface pvr_mgmt_if;
    logic bit_strobe;
    logic mgr_dout;
    logic mgr_oe;
    logic phy_dout;
    logic phy_oe;
    logic line;
    // pulled high when nobody drives
    assign line = mgr_oe ? mgr_dout : (phy_oe ? phy_dout : 1'b1);
    modport manager (output bit_strobe, output mgr_dout, output mgr_oe, input line);
    modport phy (input bit_strobe, output phy_dout, output phy_oe, input line);
endinterface

// File: rtl/pvr_phy_regs.sv
// Purpose: phy end holding the negotiation result/address and 10base-t config registers
// Assumes: frames are start 01, op 10 read / 01 write, msb first
// Notes: datapath status enters as plain inputs, control leaves as levels
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
// How it works
// [R1] negotiation done latches chosen mode bits
// [R2] result bits read-only, reset to ones
// [R3] writable address, reset 00001, msb first
// [R4] zero address forces isolate bit
// [R5] manager keeps the phy address of the last frame
// [R6] monitor bits follow negotiation state, read-only
// [R7] monitor codes from fixed state encoding
// [R8] reserved bits written zero, ignored
// [R9] link pulse bit gates pulses, forces link
// [R10] link pulse bit only at 10 Mb/s
// [R11] heartbeat bit, ignored in full duplex
// [R12] jabber bit in 10 full or loopback
// [R13] registers reached only by addressed frames
module pvr_phy_regs (
    input wire logic pclk,
    input wire logic presetn,
    pvr_mgmt_if.phy mgmt,
    input wire logic neg_done,
    input wire logic [3:0] neg_mode,
    input wire pvr_pkg::pvr_monitor_type neg_state,
    input wire logic autoneg_on,
    input wire logic speed_10,
    input wire logic full_duplex,
    input wire logic xcvr_loopback,
    input wire logic basic_isolate_in,
    output logic isolate,
    output logic link_pulse_tx,
    output logic link_forced_good,
    output logic heartbeat_on,
    output logic squelch_normal,
    output logic jabber_on
);
    logic [3:0] result_q;
    logic [4:0] addr_q;
    logic [3:0] monitor_q;
    logic [15:0] line_q;
    logic [5:0] cnt_q;
    logic busy_q;
    logic prev_q;
    logic [13:0] head_q;
    logic [15:0] shift_q;
    logic drive_q;
    logic dout_q;
    logic [15:0] result_word;
    logic [15:0] read_word;
    wire start_seen = mgmt.bit_strobe && !busy_q && !prev_q && mgmt.line;
    wire [13:0] head = {head_q[12:0], mgmt.line};
    // header keeps both start bits, so op sits at 11:10
    wire is_read = head[11:10] == 2'b10;
    wire is_write = head_q[11:10] == 2'b01;
    wire for_me = head[9:5] == addr_q; // [R13]
    wire [4:0] reg_sel = head[4:0];
    wire head_end = mgmt.bit_strobe && busy_q && cnt_q == 6'h0d;
    wire write_end = mgmt.bit_strobe && busy_q && cnt_q == pvr_pkg::frame_bits - 6'h01
        && is_write && head_q[9:5] == addr_q; // [R13]
    wire [15:0] wdata = {shift_q[14:0], mgmt.line};
    wire wr_result = write_end && head_q[4:0] == pvr_pkg::reg_result_addr;
    wire wr_line = write_end && head_q[4:0] == pvr_pkg::reg_line_cfg;
    // reserved 11:9 read back zero, never stored
    assign result_word = {result_q, 3'b000, addr_q, monitor_q}; // [R8]
    assign read_word = reg_sel == pvr_pkg::reg_result_addr ? result_word :
        reg_sel == pvr_pkg::reg_line_cfg ? line_q : 16'h0000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q <= pvr_pkg::result_reset; // [R2]
            monitor_q <= pvr_pkg::monitor_reset;
            addr_q <= pvr_pkg::station_addr_reset;
            line_q <= pvr_pkg::line_cfg_reset;
        end else begin
            if (neg_done) begin
                result_q <= neg_mode; // [R1]
            end
            monitor_q <= neg_state; // [R6] [R7]
            if (wr_result) begin
                addr_q <= wdata[pvr_pkg::addr_lsb +: 5]; // [R3]
            end
            if (wr_line) begin
                line_q <= wdata & pvr_pkg::line_cfg_wmask;
            end
        end
    end
    // frame receiver: line idles high, start pattern 0 then 1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
            prev_q <= 1'b1;
            cnt_q <= 6'h00;
            head_q <= 14'h0000;
            shift_q <= 16'h0000;
            drive_q <= 1'b0;
            dout_q <= 1'b0;
        end else if (mgmt.bit_strobe) begin
            prev_q <= mgmt.line;
            if (start_seen) begin
                busy_q <= 1'b1;
                cnt_q <= 6'h02;
                head_q <= 14'h0001;
            end else if (busy_q) begin
                cnt_q <= cnt_q + 6'h01;
                if (cnt_q < 6'h0e) begin
                    head_q <= head;
                end
                if (head_end && is_read && for_me) begin
                    // turnaround: drive both bits as zero, then data msb first
                    drive_q <= 1'b1;
                    dout_q <= 1'b0;
                    shift_q <= read_word;
                end else if (!drive_q) begin
                    shift_q <= wdata;
                end else if (cnt_q >= 6'h0f) begin
                    // shift only while replying, else the msb is lost
                    dout_q <= shift_q[15];
                    shift_q <= {shift_q[14:0], 1'b0};
                end
                if (cnt_q == pvr_pkg::frame_bits - 6'h01) begin
                    busy_q <= 1'b0;
                    drive_q <= 1'b0;
                    prev_q <= 1'b1;
                end
            end
        end
    end
    assign mgmt.phy_oe = drive_q;
    assign mgmt.phy_dout = dout_q;
    // isolate also follows basic control's own bit
    assign isolate = basic_isolate_in || addr_q == 5'h00; // [R4]
    // pulses only matter at 10 Mb/s; 100 Mb/s keeps its own link test
    assign link_pulse_tx = speed_10 && line_q[pvr_pkg::lp_bit]; // [R9] [R10]
    assign link_forced_good = speed_10 && !line_q[pvr_pkg::lp_bit]; // [R9] [R10]
    assign heartbeat_on = line_q[pvr_pkg::hb_bit] && !full_duplex; // [R11]
    assign squelch_normal = line_q[pvr_pkg::sq_bit];
    assign jabber_on = line_q[pvr_pkg::jab_bit] && speed_10
        && (full_duplex || xcvr_loopback); // [R12]
    logic unused_an;
    assign unused_an = autoneg_on;
endmodule

// File: rtl/pvr_manager.sv
// Purpose: station management end, apb slave issuing management frames
// Assumes: one frame at a time, bit strobe every clock
// Notes: software chooses the phy address per frame
`timescale 1ns/100ps
module pvr_manager (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    pvr_mgmt_if.manager mgmt
);
    logic [31:0] frame_q;
    logic [5:0] cnt_q;
    logic busy_q;
    logic rd_q;
    logic [15:0] wdata_q;
    logic [15:0] rdata_q;
    logic [9:0] target_q;
    logic [31:0] rd_mux;
    wire acc = psel && penable;
    wire wr_ctrl = acc && pwrite && paddr == pvr_pkg::apb_ctrl && !busy_q;
    wire wr_wd = acc && pwrite && paddr == pvr_pkg::apb_wdata;
    wire mapped = paddr == pvr_pkg::apb_ctrl || paddr == pvr_pkg::apb_wdata
        || paddr == pvr_pkg::apb_status || paddr == pvr_pkg::apb_rdata;
    // ctrl: [14:10] phy addr of last frame read back, [4:0] reg, [15] read
    assign rd_mux = paddr == pvr_pkg::apb_ctrl ? {17'h0, target_q, 5'h00} :
        paddr == pvr_pkg::apb_wdata ? {16'h0, wdata_q} :
        paddr == pvr_pkg::apb_status ? {31'h0, busy_q} :
        paddr == pvr_pkg::apb_rdata ? {16'h0, rdata_q} : 32'h0;
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;
    assign prdata = rd_mux;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdata_q <= 16'h0000;
            target_q <= 10'h000;
        end else begin
            if (wr_wd) begin
                wdata_q <= pwdata[15:0];
            end
            if (wr_ctrl) begin
                target_q <= pwdata[14:5]; // [R5]
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 6'h00;
            frame_q <= 32'h0000_0000;
            rdata_q <= 16'h0000;
        end else if (wr_ctrl) begin
            busy_q <= 1'b1;
            rd_q <= pwdata[15];
            cnt_q <= 6'h00;
            // msb of each address goes first
            frame_q <= {2'b01, pwdata[15] ? 2'b10 : 2'b01, pwdata[14:10], pwdata[4:0],
                2'b10, pwdata[15] ? 16'h0000 : wdata_q}; // [R3] [R8] [R13]
        end else if (busy_q) begin
            cnt_q <= cnt_q + 6'h01;
            frame_q <= {frame_q[30:0], 1'b0};
            if (rd_q && cnt_q >= 6'h10) begin
                rdata_q <= {rdata_q[14:0], mgmt.line};
            end
            if (cnt_q == pvr_pkg::frame_bits - 6'h01) begin
                busy_q <= 1'b0;
            end
        end
    end
    assign mgmt.bit_strobe = 1'b1;
    assign mgmt.mgr_dout = busy_q ? frame_q[31] : 1'b1;
    assign mgmt.mgr_oe = busy_q && !(rd_q && cnt_q >= 6'h0e);
endmodule

// File: sim/pvr_assertions.sv
// Purpose: wire checks on the management link between the two ends
// Assumes: one clock, reset active low, line pulled high
// Notes: sees only the interface signals
`timescale 1ns/100ps
module pvr_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic bit_strobe,
    input wire logic mgr_dout,
    input wire logic mgr_oe,
    input wire logic phy_dout,
    input wire logic phy_oe,
    input wire logic line
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    one_driver_a: assert property (!(mgr_oe && phy_oe)) else $error("both ends drive");
    idle_high_a: assert property (!mgr_oe && !phy_oe |-> line) else $error("idle low");
    mgr_level_a: assert property (mgr_oe |-> line == mgr_dout) else $error("mgr level");
    phy_level_a: assert property (phy_oe |-> line == phy_dout) else $error("phy level");
    start_code_a: assert property ($rose(mgr_oe) |-> !line ##1 line)
        else $error("bad start code");
    // header of 14 bits always precedes any release
    header_len_a: assert property ($rose(mgr_oe) |-> mgr_oe [*8] ##1 mgr_oe [*6])
        else $error("short hdr");
    strobe_on_a: assert property ($rose(mgr_oe) |-> bit_strobe [*8]) else $error("no strobe");
    frame_len_a: assert property ($rose(mgr_oe) |-> ##[13:33] $fell(mgr_oe))
        else $error("frame length");
    // reply is two turnaround bits and 16 data bits, then release
    reply_len_a: assert property ($rose(phy_oe) |-> phy_oe [*8] ##1 phy_oe [*8]
        ##1 phy_oe [*2] ##1 !phy_oe)
        else $error("reply length");
    turnaround_a: assert property ($rose(phy_oe) |-> !line ##1 !line)
        else $error("turnaround not low");
endmodule

// File: sim/test_phy_vendor_config_status_regs.sv
// Purpose: drives the manager over apb and the phy status inputs directly, checks registers and line outputs
// Assumes: zero wait apb, 32 clock frames
// Notes: reads to a foreign address see the pulled-up line
`timescale 1ns/100ps
module test_phy_vendor_config_status_regs;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, err, neg_done = 1'b0, speed_10 = 1'b1, full_duplex = 1'b0;
    logic autoneg_on = 1'b1, xcvr_loopback = 1'b0, basic_isolate_in = 1'b0;
    logic [3:0] neg_mode = 4'h0;
    pvr_pkg::pvr_monitor_type neg_state = pvr_pkg::mon_idle;
    logic isolate, link_pulse_tx, link_forced_good, heartbeat_on, squelch_normal, jabber_on;
    logic [15:0] rd;
    int fails = 0, samples_checked = 0;
    pvr_mgmt_if mgmt ();
    always #2.5 pclk = ~pclk;
    pvr_manager pvr_manager_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .mgmt(mgmt.manager));
    pvr_phy_regs pvr_phy_regs_i (.pclk, .presetn, .mgmt(mgmt.phy), .neg_done, .neg_mode,
        .neg_state, .autoneg_on, .speed_10, .full_duplex, .xcvr_loopback, .basic_isolate_in,
        .isolate, .link_pulse_tx, .link_forced_good, .heartbeat_on, .squelch_normal,
        .jabber_on);
    pvr_assertions pvr_assertions_i (.pclk, .presetn, .bit_strobe(mgmt.bit_strobe),
        .mgr_dout(mgmt.mgr_dout), .mgr_oe(mgmt.mgr_oe), .phy_dout(mgmt.phy_dout),
        .phy_oe(mgmt.phy_oe), .line(mgmt.line));
    task automatic chk(input string what, input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one frame; the phy address is chosen by software each time
    task automatic frame(input logic rdn, input logic [4:0] phy, rn, input logic [15:0] d);
        logic [31:0] q;
        apb(1'b1, pvr_pkg::apb_wdata, {16'h0, d}, q);
        apb(1'b1, pvr_pkg::apb_ctrl, {16'h0, rdn, phy, 5'h00, rn}, q);
        q = 32'h1;
        for (int n = 0; n < 60 && q[0] !== 1'b0; n++) apb(1'b0, pvr_pkg::apb_status, 0, q);
        chk("frame done", {15'h0, q[0]}, 16'h0);
        apb(1'b0, pvr_pkg::apb_rdata, 32'h0, q);
        rd = q[15:0];
    endtask
    task automatic reset_values();
        logic [31:0] q;
        frame(1'b1, 5'h01, pvr_pkg::reg_result_addr, 16'h0);
        chk("result and address", rd, 16'hf010);
        frame(1'b1, 5'h01, pvr_pkg::reg_line_cfg, 16'h0);
        chk("line config", rd, 16'h7800);
        chk("isolate", {15'h0, isolate}, 16'h0);
        chk("pulses on", {15'h0, link_pulse_tx}, 16'h1);
        chk("link not forced", {15'h0, link_forced_good}, 16'h0);
        chk("normal squelch", {15'h0, squelch_normal}, 16'h1);
        chk("heartbeat on", {15'h0, heartbeat_on}, 16'h1);
        chk("jabber hd", {15'h0, jabber_on}, 16'h0);
        basic_isolate_in <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("isolate follows", {15'h0, isolate}, 16'h1);
        basic_isolate_in <= 1'b0;
        apb(1'b0, 12'h010, 32'h0, q);
        chk("unmapped", {15'h0, err}, 16'h1);
    endtask
    task automatic result_and_monitor();
        pvr_pkg::pvr_monitor_type m;
        m = pvr_pkg::mon_idle;
        neg_mode <= 4'b0100;
        neg_done <= 1'b1;
        @(posedge pclk);
        neg_done <= 1'b0;
        neg_mode <= 4'b0001;
        repeat (m.num()) begin
            neg_state <= m;
            frame(1'b1, 5'h01, pvr_pkg::reg_result_addr, 16'h0);
            chk("monitor", rd, {4'h4, 3'h0, 5'h01, m});
            m = m.next;
        end
    endtask
    task automatic address_moves();
        logic [31:0] q;
        frame(1'b0, 5'h01, pvr_pkg::reg_result_addr, 16'h0050);
        frame(1'b1, 5'h01, pvr_pkg::reg_result_addr, 16'h0);
        chk("old address", rd, 16'hffff);
        frame(1'b1, 5'h05, pvr_pkg::reg_result_addr, 16'h0);
        chk("new address", rd, 16'h4058);
        apb(1'b0, pvr_pkg::apb_ctrl, 32'h0, q);
        chk("tracked phy", q[15:0], 16'h1400);
        frame(1'b0, 5'h05, pvr_pkg::reg_result_addr, 16'h0000);
        chk("isolate", {15'h0, isolate}, 16'h1);
        frame(1'b0, 5'h00, pvr_pkg::reg_result_addr, 16'h0010);
        chk("isolate off", {15'h0, isolate}, 16'h0);
    endtask
    task automatic line_config();
        frame(1'b0, 5'h01, pvr_pkg::reg_line_cfg, 16'hffff);
        frame(1'b1, 5'h01, pvr_pkg::reg_line_cfg, 16'h0);
        chk("config ro bits", rd, 16'h7800);
        full_duplex <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("jabber on", {15'h0, jabber_on}, 16'h1);
        chk("heartbeat fd", {15'h0, heartbeat_on}, 16'h0);
        full_duplex <= 1'b0;
        xcvr_loopback <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("jabber loopback", {15'h0, jabber_on}, 16'h1);
        full_duplex <= 1'b1;
        xcvr_loopback <= 1'b0;
        // heartbeat kept set as software must
        frame(1'b0, 5'h01, pvr_pkg::reg_line_cfg, 16'h2000);
        chk("pulses off", {15'h0, link_pulse_tx}, 16'h0);
        chk("forced good", {15'h0, link_forced_good}, 16'h1);
        chk("jabber off", {15'h0, jabber_on}, 16'h0);
        chk("low squelch", {15'h0, squelch_normal}, 16'h0);
        speed_10 <= 1'b0;
        full_duplex <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("no force at 100", {15'h0, link_forced_good}, 16'h0);
        chk("heartbeat hd", {15'h0, heartbeat_on}, 16'h1);
    endtask
    task automatic wrap_up();
        if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        reset_values();
        result_and_monitor();
        address_moves();
        line_config();
        wrap_up();
    end
    initial begin
        repeat (8000) @(posedge pclk);
        fails++;
        wrap_up();
    end
endmodule
